// File: hdl/timer2_regs.vh
// register offsets, field positions, reset values and timing counts for the timer block
// assumes a plain byte-wide register port with one-cycle strobes
`ifndef TIMER2_REGS_VH
`define TIMER2_REGS_VH
`define TMR_ADDR_CTRL 3'h0
`define TMR_ADDR_MODE 3'h1
`define TMR_ADDR_CNTL 3'h2
`define TMR_ADDR_CNTH 3'h3
`define TMR_ADDR_RLDL 3'h4
`define TMR_ADDR_RLDH 3'h5
`define TMR_ADDR_CLK 3'h6
// control register fields
`define TMR_CTRL_CRSEL 0
`define TMR_CTRL_CTSEL 1
`define TMR_CTRL_RUN 2
`define TMR_CTRL_TXCLK 4
`define TMR_CTRL_RXCLK 5
`define TMR_CTRL_EXTFLAG 6
`define TMR_CTRL_OVF 7
// mode register fields
`define TMR_MODE_DOWN 0
`define TMR_MODE_OE 1
// clock register field
`define TMR_CLK_DBL 0
`define TMR_CTRL_RESET 8'h00
`define TMR_MODE_RESET 8'h00
`define TMR_CNT_RESET 16'h0000
`define TMR_MAX_COUNT 16'hFFFF
// machine cycle in oscillator clocks, and clock-out prescale
`define TMR_TIMER_DIV 4'hC
`define TMR_CLKOUT_DIV 4'h2
`endif

// File: hdl/timer2_osc_div.v
// oscillator prescaler: makes one-cycle ticks at osc/12 and osc/2
// assumes ref_clk is the crystal input; double-speed bit selects divide by one or two
`timescale 1ns/10ps
`include "timer2_regs.vh"
module timer2_osc_div (
  input wire ref_clk,
  input wire rst_n,
  input wire doubleSpeed,
  output reg timerTick,
  output reg clkoutTick
);
  reg halfPhase;
  reg [3:0] cnt12;
  reg cnt2;
  wire oscTick;
  // standard mode uses every other crystal edge as the oscillator
  assign oscTick = doubleSpeed | halfPhase; // [R13]
  // oscillator phase and the two prescale counters
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfPhase <= 1'b0;
      cnt12 <= 4'h0;
      cnt2 <= 1'b0;
      timerTick <= 1'b0;
      clkoutTick <= 1'b0;
    end else begin
      halfPhase <= ~halfPhase;
      timerTick <= 1'b0;
      clkoutTick <= 1'b0;
      if (oscTick) begin
        cnt2 <= ~cnt2;
        clkoutTick <= cnt2; // [R9]
        if (cnt12 == `TMR_TIMER_DIV - 4'h1) begin
          cnt12 <= 4'h0;
          timerTick <= 1'b1; // [R2]
        end else begin
          cnt12 <= cnt12 + 4'h1;
        end
      end
    end
  end
endmodule // timer2_osc_div

// File: hdl/timer2_updown_clockout.v
// timer 2: 16-bit up/down auto-reload timer/counter with programmable clock output
// assumes pins arrive asynchronous to ref_clk; registers reached over a plain byte port
//
// Behaviour
// [R1] sixteen-bit count of low and high byte, low carrying into high
// [R2] select bit picks osc/12 ticks or external pin edges as count source
// [R3] count advances only while run control set, otherwise holds
// [R4] capture, auto-reload and baud modes chosen by rx, tx and capture/reload bits
// [R5] down-count enable clear gives plain up-counting auto-reload
// [R6] counting up, overflow past FFFFh sets flag, interrupts, reloads the pair
// [R7] counting down, count equal to reload sets flag and loads FFFFh
// [R8] up/down mode toggles external flag each wrap, no interrupt from it
// [R9] clock-out mode counts at osc/2, reloading at each overflow
// [R10] clock-out mode raises no interrupt on overflow
// [R11] clock-out pin carries 50% clock at osc/(4*(65536-reload))
// [R12] software sets output enable, clears select bit, writes reload value
// [R13] oscillator is crystal/2 normally, crystal undivided with double speed
// [R14] clock-out pin inverts on each overflow
`timescale 1ns/10ps
`include "timer2_regs.vh"
module timer2_updown_clockout (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire countPinIn,
  output reg countPinOut,
  output reg countPinOe,
  input wire directionPin,
  output reg irqReq
);
  reg [7:0] timerControlReg;
  reg [7:0] timerModeReg;
  reg [7:0] countLowByte;
  reg [7:0] countHighByte;
  reg [7:0] reloadLowByte;
  reg [7:0] reloadHighByte;
  reg doubleSpeedBit;
  reg pinSync1, pinSync2, pinPrev;
  reg dirSync1, dirSync2;
  reg [15:0] next_count;
  reg next_ovf;
  reg next_ext;
  reg next_wrap;
  wire timerTick;
  wire clkoutTick;
  wire [15:0] count;
  wire [15:0] reload;
  wire run, ctSel, crSel, baudMode, downEn, clkOe, clkoutMode, stepTick, pinFall;

  // byte-addressed read decode, used by read path
  function [7:0] rd_mux;
    input [2:0] a;
    begin
      case (a)
        `TMR_ADDR_CTRL: rd_mux = timerControlReg;
        `TMR_ADDR_MODE: rd_mux = {6'h00, timerModeReg[1:0]};
        `TMR_ADDR_CNTL: rd_mux = countLowByte;
        `TMR_ADDR_CNTH: rd_mux = countHighByte;
        `TMR_ADDR_RLDL: rd_mux = reloadLowByte;
        `TMR_ADDR_RLDH: rd_mux = reloadHighByte;
        `TMR_ADDR_CLK: rd_mux = {7'h00, doubleSpeedBit};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  timer2_osc_div timer2_osc_div_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .doubleSpeed(doubleSpeedBit),
    .timerTick(timerTick),
    .clkoutTick(clkoutTick)
  );

  assign count = {countHighByte, countLowByte}; // [R1]
  assign reload = {reloadHighByte, reloadLowByte};
  assign run = timerControlReg[`TMR_CTRL_RUN];
  assign ctSel = timerControlReg[`TMR_CTRL_CTSEL];
  assign crSel = timerControlReg[`TMR_CTRL_CRSEL];
  // either serial clock select takes baud mode, which overrides capture/reload
  assign baudMode = timerControlReg[`TMR_CTRL_RXCLK] | timerControlReg[`TMR_CTRL_TXCLK]; // [R4]
  assign downEn = timerModeReg[`TMR_MODE_DOWN];
  assign clkOe = timerModeReg[`TMR_MODE_OE];
  // clock-out needs output enable and timer operation
  assign clkoutMode = clkOe & ~ctSel; // [R12]
  assign pinFall = pinPrev & ~pinSync2;
  // count source: clock-out prescale, osc/12, or falling edge on the count pin
  assign stepTick = run & (clkoutMode ? clkoutTick : (ctSel ? pinFall : timerTick)); // [R2] [R3] [R9]

  // two-flop synchronisers for pins, then edge history
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      pinPrev <= 1'b0;
      dirSync1 <= 1'b0;
      dirSync2 <= 1'b0;
    end else begin
      pinSync1 <= countPinIn;
      pinSync2 <= pinSync1;
      pinPrev <= pinSync2;
      dirSync1 <= directionPin;
      dirSync2 <= dirSync1;
    end
  end

  // next count, overflow, toggle and wrap flags
  always @* begin
    next_count = count;
    next_ovf = 1'b0;
    next_ext = 1'b0;
    next_wrap = 1'b0;
    if (stepTick) begin
      if (!baudMode && downEn && !dirSync2 && !clkoutMode) begin
        // down count: underflow when count hits the reload value
        if (count == reload) begin
          next_count = `TMR_MAX_COUNT; // [R7]
          next_ovf = 1'b1;
          next_ext = 1'b1; // [R8]
        end else begin
          next_count = count - 16'h0001;
        end
      end else if (count == `TMR_MAX_COUNT) begin
        next_wrap = 1'b1;
        // capture mode free-runs to zero; other modes reload
        next_count = (crSel && !baudMode && !clkoutMode) ? 16'h0000 : reload; // [R6] [R9]
        next_ovf = ~clkoutMode & ~baudMode; // [R10]
        next_ext = downEn & ~crSel & ~baudMode & ~clkoutMode; // [R8]
      end else begin
        next_count = count + 16'h0001; // [R1] [R5]
      end
    end
  end

  // registers: hardware set of flags wins over a software write in the same cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerControlReg <= `TMR_CTRL_RESET;
      timerModeReg <= `TMR_MODE_RESET;
      countLowByte <= 8'h00;
      countHighByte <= 8'h00;
      reloadLowByte <= 8'h00;
      reloadHighByte <= 8'h00;
      doubleSpeedBit <= 1'b0;
    end else begin
      countLowByte <= next_count[7:0];
      countHighByte <= next_count[15:8];
      if (regWrite) begin
        case (regAddr)
          `TMR_ADDR_CTRL: timerControlReg <= regWdata;
          `TMR_ADDR_MODE: timerModeReg <= {6'h00, regWdata[1:0]};
          `TMR_ADDR_CNTL: countLowByte <= regWdata;
          `TMR_ADDR_CNTH: countHighByte <= regWdata;
          `TMR_ADDR_RLDL: reloadLowByte <= regWdata;
          `TMR_ADDR_RLDH: reloadHighByte <= regWdata;
          `TMR_ADDR_CLK: doubleSpeedBit <= regWdata[`TMR_CLK_DBL]; // [R13]
          default: ;
        endcase
      end
      if (next_ovf) begin
        timerControlReg[`TMR_CTRL_OVF] <= 1'b1; // [R6] [R7]
      end
      if (next_ext) begin
        // toggle against the value software just wrote, if any
        timerControlReg[`TMR_CTRL_EXTFLAG] <= ~((regWrite && regAddr == `TMR_ADDR_CTRL) ?
          regWdata[`TMR_CTRL_EXTFLAG] : timerControlReg[`TMR_CTRL_EXTFLAG]); // [R8]
      end
    end
  end

  // outputs: read data one cycle after strobe, pin and interrupt from flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
      countPinOut <= 1'b0;
      countPinOe <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      regRdata <= regRead ? rd_mux(regAddr) : 8'h00;
      countPinOe <= clkoutMode; // [R11]
      if (!clkoutMode) begin
        countPinOut <= 1'b0;
      end else if (next_wrap) begin
        countPinOut <= ~countPinOut; // [R14] [R11]
      end
      // only the overflow flag asks for service; the toggle flag never does
      irqReq <= timerControlReg[`TMR_CTRL_OVF] | next_ovf; // [R8] [R10]
    end
  end
endmodule // timer2_updown_clockout

// File: bench/count_pin_model.sv
// far-side pins: external count pin and direction pin
// assumes the bench calls its tasks between clock edges
`timescale 1ns/10ps
module count_pin_model (
  input wire ref_clk,
  output logic pinOut,
  output logic dirOut
);
  // idle high so the first pulse gives a clean falling edge
  initial begin
    pinOut = 1'b1;
    dirOut = 1'b1;
  end
  // each level held 4 cycles, well past the two-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      pinOut <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pinOut <= 1'b1;
    end
  endtask
  task automatic setDir(input logic v);
    @(posedge ref_clk);
    dirOut <= v;
  endtask
endmodule // count_pin_model

// File: bench/timer2_updown_clockout_asserts.sv
// port checker for the timer block
// assumes binding to the timer top module
`timescale 1ns/10ps
module timer2_updown_clockout_asserts (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  input wire countPinIn,
  input wire countPinOut,
  input wire countPinOe,
  input wire directionPin,
  input wire irqReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // reload bytes read back as written, one idle cycle apart
  reload_low_a: assert property (regRead && regAddr == 3'h4 && $past(regWrite, 2) && $past(regAddr, 2) == 3'h4
    && !$past(regWrite) |=> regRdata == $past(regWdata, 3)) else $error("reload low readback wrong");
  reload_high_a: assert property (regRead && regAddr == 3'h5 && $past(regWrite, 2) && $past(regAddr, 2) == 3'h5
    && !$past(regWrite) |=> regRdata == $past(regWdata, 3)) else $error("reload high readback wrong");
  // pin direction only follows a register write
  oe_after_write_a: assert property ($changed(countPinOe) |-> $past(regWrite) || $past(regWrite, 2)
    || $past(regWrite, 3)) else $error("pin enable moved without a write");
  pin_quiet_off_a: assert property (!countPinOe |-> !countPinOut) else $error("pin level while undriven");
  clkout_no_irq_a: assert property (countPinOe && $past(countPinOe, 3) |-> !$rose(irqReq))
    else $error("interrupt in clock-out mode");
  // fastest clock-out half period is two cycles
  toggle_space_a: assert property ($changed(countPinOut) && $past(countPinOe) && countPinOe
    |=> !$changed(countPinOut) || !countPinOe) else $error("clock-out toggled too fast");
  // flag is sticky: only software clears it
  irq_clear_a: assert property ($fell(irqReq) |-> $past(regWrite) || $past(regWrite, 2) || $past(regWrite, 3))
    else $error("interrupt dropped without a write");
  flag_read_a: assert property (regRead && regAddr == 3'h0 && irqReq && !$past(regWrite) |=> regRdata[7])
    else $error("flag not seen while interrupt high");
  cover property ($rose(irqReq));
  cover property ($rose(countPinOe));
  cover property ($changed(countPinOut) && countPinOe);
endmodule // timer2_updown_clockout_asserts
bind timer2_updown_clockout timer2_updown_clockout_asserts timer2_updown_clockout_asserts_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .countPinIn(countPinIn), .countPinOut(countPinOut), .countPinOe(countPinOe),
  .directionPin(directionPin), .irqReq(irqReq));

// File: bench/timer2_updown_clockout_tb_top.sv
// self-checking bench for the timer block
// assumes the pin model and checker compiled beforehand
`timescale 1ns/10ps
module timer2_updown_clockout_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic countPinIn, countPinOut, countPinOe, directionPin, irqReq;
  int nErrors = 0;
  int compares = 0;
  time t0;
  always #4 ref_clk = ~ref_clk;
  timer2_updown_clockout timer2_updown_clockout_i (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .countPinIn(countPinIn),
    .countPinOut(countPinOut), .countPinOe(countPinOe), .directionPin(directionPin), .irqReq(irqReq));
  count_pin_model count_pin_model_i (.ref_clk(ref_clk), .pinOut(countPinIn), .dirOut(directionPin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // bounded: carry through the low byte takes about 3100 cycles
  task automatic wait_irq;
    for (int k = 0; k < 4000 && irqReq !== 1'b1; k++) @(posedge ref_clk);
    chk({7'h00, irqReq}, 8'h01);
  endtask
  // up count from FEFF carries into the high byte, then reloads
  task automatic up_reload;
    wr(3'h6, 8'h01);
    wr(3'h4, 8'hF0);
    wr(3'h5, 8'hFF);
    wr(3'h2, 8'hFF);
    wr(3'h3, 8'hFE);
    wr(3'h0, 8'h04);
    wait_irq;
    rd(3'h2, 8'hF0);
    rd(3'h3, 8'hFF);
    rd(3'h0, 8'h84);
  endtask
  task automatic down_count;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    count_pin_model_i.setDir(1'b0);
    wr(3'h4, 8'hFE);
    wr(3'h5, 8'h12);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h13);
    wr(3'h0, 8'h04);
    wait_irq;
    rd(3'h2, 8'hFF);
    rd(3'h3, 8'hFF);
    rd(3'h0, 8'hC4);
  endtask
  // pin edges counted, timer ticks ignored, then the count holds
  task automatic ext_count;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h10);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h06);
    count_pin_model_i.pulses(3);
    repeat (6) @(posedge ref_clk);
    rd(3'h2, 8'h13);
    wr(3'h0, 8'h00);
    repeat (60) @(posedge ref_clk);
    rd(3'h2, 8'h13);
  endtask
  // reload FFFE: half period 2*(65536-reload) osc clocks
  task automatic clock_out;
    wr(3'h4, 8'hFE);
    rd(3'h4, 8'hFE);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'hFF);
    // start near the top so the first overflow comes within a few cycles
    wr(3'h2, 8'hFE);
    wr(3'h3, 8'hFF);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h04);
    for (int x = 1; x >= 0; x--) begin
      wr(3'h6, 8'(x));
      @(countPinOut);
      @(countPinOut);
      t0 = $time;
      @(countPinOut);
      chk(8'(($time - t0) / 8), x ? 8'h04 : 8'h08);
      t0 = $time;
      @(countPinOut);
      chk(8'(($time - t0) / 8), x ? 8'h04 : 8'h08);
    end
    chk({6'h00, countPinOe, irqReq}, 8'h02);
  endtask
  task automatic give_verdict;
    if (nErrors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    up_reload;
    down_count;
    ext_count;
    clock_out;
    give_verdict;
  end
  // whole run needs under 5000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    give_verdict;
  end
endmodule // timer2_updown_clockout_tb_top
